// ### rtl/blc_pkg.sv
// constants, state types and field layouts for the backlight control block
// assumes a single 125 MHz clock and a synchronous active-high reset
package blc_pkg;

    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned SINKS         = 7;
    localparam int unsigned LEVELS        = 4;

    // level codes
    localparam logic [2:0] CODE_DARK      = 3'h4;
    localparam logic [2:0] CODE_INDOOR    = 3'h3;
    localparam logic [2:0] CODE_OFFICE    = 3'h2;
    localparam logic [2:0] CODE_BRIGHT    = 3'h1;
    localparam logic [2:0] CODE_OUTDOOR   = 3'h0;

    // interrupt flag positions
    localparam int unsigned FLAG_FADE     = 0;
    localparam int unsigned FLAG_MAIN     = 1;
    localparam int unsigned FLAG_SECOND   = 2;
    localparam int unsigned FLAG_OVP      = 3;
    localparam int unsigned FLAG_TSD      = 4;
    localparam int unsigned FLAG_SHORT    = 5;
    localparam int unsigned FLAGS         = 6;

    // timing figures in ms
    localparam int unsigned SCP_ARM_MS    = 4;
    localparam int unsigned ON_T0_MS      = 200;
    localparam int unsigned T600_MS       = 600;
    localparam int unsigned T800_MS       = 800;
    localparam int unsigned T1200_MS      = 1200;
    localparam int unsigned FILT_MIN_MS   = 80;
    localparam int unsigned FILT_MAX_MS   = 10000;

    // one millisecond tick
    localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;

    localparam logic [1:0] OFF_DISABLED   = 2'h0;

    typedef enum logic [2:0] {
        PWR_STANDBY  = 3'b000,
        PWR_SOFTSTART= 3'b001,
        PWR_RUN      = 3'b010,
        PWR_SHORT    = 3'b011,
        PWR_HOT      = 3'b100
    } pwr_e;

    typedef enum logic [1:0] {
        BLK_IDLE = 2'b00,
        BLK_ON   = 2'b01,
        BLK_OFF  = 2'b10
    } blink_e;

endpackage : blc_pkg

// ### rtl/blink_timer.sv
// one independent sink's blink sequencer
// assumes a 1 ms tick from the parent and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module blink_timer (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       ms_tick,
    input  wire logic       enable,
    input  wire logic [1:0] on_sel,
    input  wire logic [1:0] off_sel,
    output logic            sink_on
);
    typedef struct packed {
        blc_pkg::blink_e phase;
        logic [10:0]     count;
        logic            on;
    } state_s;

    state_s cur;
    state_s nxt;
    logic [10:0] on_ms;
    logic [10:0] off_ms;

    always_comb begin
        case (on_sel)
            2'h0:    on_ms = 11'(blc_pkg::ON_T0_MS);
            2'h1:    on_ms = 11'(blc_pkg::T600_MS);
            2'h2:    on_ms = 11'(blc_pkg::T800_MS);
            default: on_ms = 11'(blc_pkg::T1200_MS);
        endcase
        case (off_sel)
            2'h1:    off_ms = 11'(blc_pkg::T600_MS);
            2'h2:    off_ms = 11'(blc_pkg::T800_MS);
            default: off_ms = 11'(blc_pkg::T1200_MS);
        endcase
    end

    always_comb begin
        nxt = cur;
        case (cur.phase)
            blc_pkg::BLK_IDLE: begin
                nxt.on = enable;
                nxt.count = '0;
                if (enable && off_sel != blc_pkg::OFF_DISABLED) begin
                    nxt.phase = blc_pkg::BLK_ON;
                end
            end
            blc_pkg::BLK_ON: begin
                nxt.on = 1'b1;
                if (ms_tick) begin
                    nxt.count = cur.count + 11'h001;
                end
                if (!enable || off_sel == blc_pkg::OFF_DISABLED) begin
                    nxt.phase = blc_pkg::BLK_IDLE;
                    nxt.on = 1'b0;
                end else if (ms_tick && cur.count + 11'h001 >= on_ms) begin
                    nxt.phase = blc_pkg::BLK_OFF;
                    nxt.count = '0;
                    nxt.on = 1'b0;
                end
            end
            blc_pkg::BLK_OFF: begin
                nxt.on = 1'b0;
                if (ms_tick) begin
                    nxt.count = cur.count + 11'h001;
                end
                if (!enable || off_sel == blc_pkg::OFF_DISABLED) begin
                    nxt.phase = blc_pkg::BLK_IDLE;
                end else if (ms_tick && cur.count + 11'h001 >= off_ms) begin
                    nxt.phase = blc_pkg::BLK_ON;
                    nxt.count = '0;
                    nxt.on = 1'b1;
                end
            end
            default: begin
                nxt.phase = blc_pkg::BLK_IDLE;
                nxt.on = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cur <= '{phase: blc_pkg::BLK_IDLE, count: 11'h000, on: 1'b0};
        end else begin
            cur <= nxt;
        end
    end

    assign sink_on = cur.on;
endmodule : blink_timer
`default_nettype wire

// ### rtl/backlight_level_blink_fault_ctrl.sv
// level selection, independent sink blink control and fault/interrupt handling
// assumes all inputs synchronous to clock; fade engine and comparators live outside
`timescale 1ns/1ps
`default_nettype none
module backlight_level_blink_fault_ctrl #(
    parameter int unsigned SINK_COUNT = blc_pkg::SINKS,
    parameter int unsigned MS_CYCLES  = blc_pkg::MS_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  srst,
    // mode and selection
    input  wire logic                  auto_level_enable,
    input  wire logic                  keypad_als_enable,
    input  wire logic [SINK_COUNT-1:0] sink_select,
    input  wire logic                  use_second_sensor,
    input  wire logic [2:0]            host_level_code,
    input  wire logic [13:0]           filter_ms,
    // main and second sensor raw level outputs, bit 0 is level 1
    input  wire logic [3:0]            main_level_raw,
    input  wire logic [3:0]            second_level_raw,
    // independent sinks
    input  wire logic [SINK_COUNT-1:0] sink_enable,
    input  wire logic [1:0]            blink_on_time,
    input  wire logic [2*SINK_COUNT-1:0] off_time,
    // power and faults
    input  wire logic                  standby_release_write,
    input  wire logic                  short_detect,
    input  wire logic                  ovp_detect,
    input  wire logic                  overtemp_detect,
    input  wire logic                  soft_start_done,
    input  wire logic                  fade_sequence_done,
    // interrupt registers
    input  wire logic [5:0]            flag_clear,
    input  wire logic [5:0]            flag_enable,
    // outputs
    output logic [2:0]                 brightness_level_code,
    output logic [2:0]                 seventh_sink_level_code,
    output logic                       seventh_sink_als,
    output logic [3:0]                 main_level_status,
    output logic [3:0]                 second_level_status,
    output logic [SINK_COUNT-1:0]      backlight_group,
    output logic [SINK_COUNT-1:0]      independent_sink_on,
    output logic                       pump_enable,
    output logic                       device_active,
    output logic                       soft_start_run,
    output logic                       standby_release,
    output logic [5:0]                 flags,
    output logic                       irq_out_n
);
    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (SINK_COUNT < 1 || SINK_COUNT > 7) begin : g_bad_sinks
        $error("SINK_COUNT must be 1 to 7");
    end
    // ms divider is 17 bits and the arm counter 20 bits wide
    if (MS_CYCLES < 2 || MS_CYCLES > (1 << 17)) begin : g_bad_ms
        $error("MS_CYCLES must be 2 to 131072");
    end

    localparam int unsigned ARM_CYCLES = blc_pkg::SCP_ARM_MS * MS_CYCLES;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [16:0]  ms_div;
        logic         ms_tick;
        logic [3:0]   main_level;
        logic [3:0]   second_level;
        logic [13:0]  main_filt;
        logic [13:0]  second_filt;
        logic [2:0]   level_code;
        logic [2:0]   d7_code;
        blc_pkg::pwr_e pwr;
        logic [19:0]  arm_count;
        logic         short_armed;
        logic         ovp_prev;
        logic [5:0]   flags;
    } state_s;

    state_s cur;
    state_s nxt;

    logic [3:0] sel_level;
    logic [2:0] enc_code;
    logic [13:0] filt_lim;
    logic [5:0] events;

    // clamp the filter window to its documented span
    always_comb begin
        if (filter_ms < 14'(blc_pkg::FILT_MIN_MS)) begin
            filt_lim = 14'(blc_pkg::FILT_MIN_MS);
        end else if (filter_ms > 14'(blc_pkg::FILT_MAX_MS)) begin
            filt_lim = 14'(blc_pkg::FILT_MAX_MS);
        end else begin
            filt_lim = filter_ms;
        end
    end

    // ****************************************************************
    // level encoder
    // ****************************************************************
    assign sel_level = use_second_sensor ? cur.second_level : cur.main_level;

    always_comb begin
        if (sel_level[3]) begin
            enc_code = blc_pkg::CODE_DARK;
        end else if (sel_level[2]) begin
            enc_code = blc_pkg::CODE_INDOOR;
        end else if (sel_level[1]) begin
            enc_code = blc_pkg::CODE_OFFICE;
        end else if (sel_level[0]) begin
            enc_code = blc_pkg::CODE_BRIGHT;
        end else begin
            enc_code = blc_pkg::CODE_OUTDOOR;
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt = cur;
        events = '0;

        // millisecond tick
        nxt.ms_tick = 1'b0;
        if (cur.ms_div == 17'(MS_CYCLES - 1)) begin
            nxt.ms_div = '0;
            nxt.ms_tick = 1'b1;
        end else begin
            nxt.ms_div = cur.ms_div + 17'h00001;
        end

        // filter: raw must differ from the held level for the whole window
        if (main_level_raw == cur.main_level) begin
            nxt.main_filt = '0;
        end else if (cur.ms_tick) begin
            if (cur.main_filt + 14'h0001 >= filt_lim) begin
                nxt.main_level = main_level_raw;
                nxt.main_filt = '0;
                events[blc_pkg::FLAG_MAIN] = 1'b1;
            end else begin
                nxt.main_filt = cur.main_filt + 14'h0001;
            end
        end
        if (second_level_raw == cur.second_level) begin
            nxt.second_filt = '0;
        end else if (cur.ms_tick) begin
            if (cur.second_filt + 14'h0001 >= filt_lim) begin
                nxt.second_level = second_level_raw;
                nxt.second_filt = '0;
                events[blc_pkg::FLAG_SECOND] = 1'b1;
            end else begin
                nxt.second_filt = cur.second_filt + 14'h0001;
            end
        end

        // level code ownership
        if (auto_level_enable) begin
            nxt.level_code = enc_code;
        end else begin
            nxt.level_code = host_level_code;
        end
        // seventh sink picks its own row from the same level
        nxt.d7_code = enc_code;

        // power and fault sequencing
        case (cur.pwr)
            blc_pkg::PWR_STANDBY: begin
                if (standby_release_write) begin
                    nxt.pwr = blc_pkg::PWR_SOFTSTART;
                    nxt.arm_count = '0;
                    nxt.short_armed = 1'b0;
                end
            end
            blc_pkg::PWR_SOFTSTART, blc_pkg::PWR_RUN: begin
                if (cur.pwr == blc_pkg::PWR_SOFTSTART && soft_start_done) begin
                    nxt.pwr = blc_pkg::PWR_RUN;
                end
                // short sensing blind until armed
                if (!cur.short_armed) begin
                    if (cur.arm_count == 20'(ARM_CYCLES - 1)) begin
                        nxt.short_armed = 1'b1;
                    end else begin
                        nxt.arm_count = cur.arm_count + 20'h00001;
                    end
                end
                if (overtemp_detect) begin
                    nxt.pwr = blc_pkg::PWR_HOT;
                end else if (cur.short_armed && short_detect) begin
                    nxt.pwr = blc_pkg::PWR_SHORT;
                    events[blc_pkg::FLAG_SHORT] = 1'b1;
                end else if (standby_release_write
                             && cur.pwr == blc_pkg::PWR_RUN) begin
                    nxt.pwr = blc_pkg::PWR_RUN;
                end
            end
            blc_pkg::PWR_SHORT: begin
                if (standby_release_write) begin
                    nxt.pwr = blc_pkg::PWR_SOFTSTART;
                    nxt.arm_count = '0;
                    nxt.short_armed = 1'b0;
                end
            end
            blc_pkg::PWR_HOT: begin
                // restart only once cooled
                if (!overtemp_detect && standby_release_write) begin
                    nxt.pwr = blc_pkg::PWR_SOFTSTART;
                    nxt.arm_count = '0;
                    nxt.short_armed = 1'b0;
                end
            end
            default: begin
                nxt.pwr = blc_pkg::PWR_STANDBY;
            end
        endcase

        // flag sources
        nxt.ovp_prev = ovp_detect;
        if (ovp_detect && !cur.ovp_prev) begin
            events[blc_pkg::FLAG_OVP] = 1'b1;
        end
        // level, not edge: a cleared flag comes back while still hot
        if (overtemp_detect) begin
            events[blc_pkg::FLAG_TSD] = 1'b1;
        end
        if (fade_sequence_done) begin
            events[blc_pkg::FLAG_FADE] = 1'b1;
        end

        // set wins over write-one-clear
        nxt.flags = (cur.flags & ~flag_clear) | events;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            cur <= '{ms_div: 17'h00000, ms_tick: 1'b0, main_level: 4'h0,
                     second_level: 4'h0, main_filt: 14'h0000,
                     second_filt: 14'h0000, level_code: 3'h0, d7_code: 3'h0,
                     pwr: blc_pkg::PWR_STANDBY, arm_count: 20'h00000,
                     short_armed: 1'b0, ovp_prev: 1'b0, flags: 6'h00};
        end else begin
            cur <= nxt;
        end
    end

    // ****************************************************************
    // independent sinks
    // ****************************************************************
    for (genvar i = 0; i < SINK_COUNT; i++) begin : g_sink
        logic blink_on;
        blink_timer u_blink (
            .clock   (clock),
            .srst    (srst),
            .ms_tick (cur.ms_tick),
            .enable  (sink_enable[i] & sink_select[i] & device_active),
            .on_sel  (blink_on_time),
            .off_sel (off_time[2*i +: 2]),
            .sink_on (blink_on)
        );
        assign independent_sink_on[i] = blink_on;
        assign backlight_group[i] = ~sink_select[i];
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign brightness_level_code   = cur.level_code;
    assign seventh_sink_als        = keypad_als_enable & sink_select[SINK_COUNT-1];
    assign seventh_sink_level_code = cur.d7_code;
    assign main_level_status       = cur.main_level;
    assign second_level_status     = cur.second_level;
    assign device_active           = (cur.pwr == blc_pkg::PWR_SOFTSTART)
                                   | (cur.pwr == blc_pkg::PWR_RUN);
    assign soft_start_run          = (cur.pwr == blc_pkg::PWR_SOFTSTART);
    assign standby_release         = device_active;
    assign pump_enable             = device_active & ~ovp_detect;
    assign flags                   = cur.flags;
    assign irq_out_n               = ~|(cur.flags & flag_enable);
endmodule : backlight_level_blink_fault_ctrl
`default_nettype wire

// ### verif/blc_asserts.sv
// concurrent checks on the backlight control block's ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module blc_asserts #(
    parameter int unsigned SINK_COUNT = blc_pkg::SINKS,
    parameter int unsigned MS_CYCLES  = blc_pkg::MS_CYCLES
) (
    input wire logic                  clock,
    input wire logic                  srst,
    input wire logic                  auto_level_enable,
    input wire logic                  keypad_als_enable,
    input wire logic [SINK_COUNT-1:0] sink_select,
    input wire logic                  use_second_sensor,
    input wire logic [2:0]            host_level_code,
    input wire logic                  ovp_detect,
    input wire logic                  overtemp_detect,
    input wire logic                  fade_sequence_done,
    input wire logic [5:0]            flag_clear,
    input wire logic [5:0]            flag_enable,
    input wire logic [2:0]            brightness_level_code,
    input wire logic                  seventh_sink_als,
    input wire logic [3:0]            main_level_status,
    input wire logic [SINK_COUNT-1:0] backlight_group,
    input wire logic                  pump_enable,
    input wire logic [5:0]            flags,
    input wire logic                  irq_out_n
);
    // ****************
    // checks
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    function automatic logic [2:0] enc(input logic [3:0] s);
        return s[3] ? 3'h4 : s[2] ? 3'h3 : s[1] ? 3'h2 : s[0] ? 3'h1 : 3'h0;
    endfunction : enc
    irq_or_a: assert property (irq_out_n == !(|(flags & flag_enable)))
        else $error("irq output disagrees with enabled flags");
    group_sel_a: assert property (backlight_group == ~sink_select)
        else $error("backlight group is not the inverse of sink select");
    seventh_als_a: assert property (
        seventh_sink_als == (keypad_als_enable && sink_select[SINK_COUNT-1]))
        else $error("seventh sink sensing enable wrong");
    host_code_a: assert property (!auto_level_enable ##1 !auto_level_enable
        |-> brightness_level_code == $past(host_level_code))
        else $error("manual level code not followed");
    // the code register takes the sensor choice of the cycle before
    auto_code_a: assert property (auto_level_enable && $past(auto_level_enable)
        && !$past(use_second_sensor)
        |-> brightness_level_code == enc($past(main_level_status)))
        else $error("automatic level code wrong");
    main_flag_a: assert property (main_level_status != $past(main_level_status)
        |-> flags[blc_pkg::FLAG_MAIN])
        else $error("main sensor flag missing after level change");
    ovp_pump_a: assert property (ovp_detect |-> !pump_enable)
        else $error("pump enabled during overvoltage");
    ovp_flag_a: assert property ($rose(ovp_detect) |=> flags[blc_pkg::FLAG_OVP])
        else $error("overvoltage flag missing");
    tsd_flag_a: assert property (overtemp_detect |=> flags[blc_pkg::FLAG_TSD])
        else $error("thermal flag not held while hot");
    fade_flag_a: assert property (fade_sequence_done |=> flags[blc_pkg::FLAG_FADE])
        else $error("fade done flag missing");
    fade_clear_a: assert property (flag_clear[0] && !fade_sequence_done |=> !flags[0])
        else $error("fade done flag not cleared");
    auto_cov: cover property (auto_level_enable && brightness_level_code == 3'h4);
    irq_cov: cover property ($fell(irq_out_n));
    ovp_cov: cover property ($rose(ovp_detect));
endmodule : blc_asserts
bind backlight_level_blink_fault_ctrl blc_asserts #(
    .SINK_COUNT(SINK_COUNT), .MS_CYCLES(MS_CYCLES)
) i_chk (
    .clock(clock), .srst(srst), .auto_level_enable(auto_level_enable),
    .keypad_als_enable(keypad_als_enable), .sink_select(sink_select),
    .use_second_sensor(use_second_sensor), .host_level_code(host_level_code),
    .ovp_detect(ovp_detect), .overtemp_detect(overtemp_detect),
    .fade_sequence_done(fade_sequence_done), .flag_clear(flag_clear),
    .flag_enable(flag_enable), .brightness_level_code(brightness_level_code),
    .seventh_sink_als(seventh_sink_als), .main_level_status(main_level_status),
    .backlight_group(backlight_group), .pump_enable(pump_enable), .flags(flags),
    .irq_out_n(irq_out_n)
);
`default_nettype wire

// ### verif/host_model.sv
// host side: one-cycle register write strobes
// assumes callers enter just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clock,
    output logic            standby_release_write,
    output logic [5:0]      flag_clear
);
    // ****************
    // write strobes
    // ****************
    initial begin
        standby_release_write = 1'b0;
        flag_clear = 6'h00;
    end
    // a write of one to the release bit, held for exactly one edge
    task automatic release_write();
        standby_release_write = 1'b1;
        @(posedge clock);
        #1 standby_release_write = 1'b0;
    endtask : release_write
    // write one to clear, no other flags touched
    task automatic clear(input logic [5:0] mask);
        flag_clear = mask;
        @(posedge clock);
        #1 flag_clear = 6'h00;
    endtask : clear
endmodule : host_model
`default_nettype wire

// ### verif/tb_backlight_level_blink_fault_ctrl.sv
// self-checking bench for the backlight control block
// assumes MS_CYCLES of 10, so one ms is ten clocks
`timescale 1ns/1ps
`default_nettype none
module tb_backlight_level_blink_fault_ctrl;
    localparam int unsigned MS = 10;
    logic clock = 1'b0, srst = 1'b1, auto_en = 1'b0, kp_als = 1'b0, use2 = 1'b0;
    logic [6:0] sel = 7'h00, sen = 7'h00, grp, isc_on;
    logic [2:0] host_code = 3'h0, code, code7;
    logic [13:0] filt = 14'h0050, off_t = 14'h0000;
    logic [3:0] raw1 = 4'h0, raw2 = 4'h0, st1, st2;
    logic [1:0] on_t = 2'h0;
    logic shrt = 1'b0, ovp = 1'b0, hot = 1'b0, ssd = 1'b0, fdone = 1'b0;
    logic [5:0] fen = 6'h00, fclr, flags;
    logic als7, pump, active, ss_run, rel, rel_wr, irq_n;
    int num_errors = 0, tests_run = 0, cycles = 0;
    logic [3:0] raws [5] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'h0};
    logic [2:0] codes [5] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    always #4 clock = ~clock;
    host_model i_host (.clock(clock), .standby_release_write(rel_wr), .flag_clear(fclr));
    backlight_level_blink_fault_ctrl #(.MS_CYCLES(MS)) i_dut (
        .clock(clock), .srst(srst), .auto_level_enable(auto_en), .keypad_als_enable(kp_als),
        .sink_select(sel), .use_second_sensor(use2), .host_level_code(host_code),
        .filter_ms(filt), .main_level_raw(raw1), .second_level_raw(raw2),
        .sink_enable(sen), .blink_on_time(on_t), .off_time(off_t),
        .standby_release_write(rel_wr), .short_detect(shrt), .ovp_detect(ovp),
        .overtemp_detect(hot), .soft_start_done(ssd), .fade_sequence_done(fdone),
        .flag_clear(fclr), .flag_enable(fen), .brightness_level_code(code),
        .seventh_sink_level_code(code7), .seventh_sink_als(als7),
        .main_level_status(st1), .second_level_status(st2), .backlight_group(grp),
        .independent_sink_on(isc_on), .pump_enable(pump), .device_active(active),
        .soft_start_run(ss_run), .standby_release(rel), .flags(flags), .irq_out_n(irq_n));
    // ****************
    // helpers
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // ceiling well above the roughly 17k cycles the sequence needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            summarize();
        end
    end
    // ****************
    // sequence
    // ****************
    initial begin
        step(8);
        srst = 1'b0;
        step(1);
        check("flags", flags, 0);
        check("irq", irq_n, 1);
        check("active", active, 0);
        $display("test reset done");
        sel = 7'h55;
        host_code = 3'h5;
        step(2);
        check("group", grp, 7'h2A);
        check("als7", als7, 0);
        kp_als = 1'b1;
        step(1);
        check("als7", als7, 1);
        check("code", code, 3'h5);
        $display("test select done");
        auto_en = 1'b1;
        fen = 6'h02;
        for (int i = 0; i < 5; i++) begin
            raw1 = raws[i];
            step(70 * MS);
            check("filter", st1, (i == 0) ? 4'h0 : raws[i-1]);
            step(20 * MS);
            check("status", st1, raws[i]);
            check("code", code, codes[i]);
            check("code7", code7, codes[i]);
            check("mainflag", flags[1], 1);
            check("irq", irq_n, 0);
            i_host.clear(6'h02);
            step(1);
            check("irq", irq_n, 1);
        end
        raw2 = 4'h2;
        step(90 * MS);
        check("second", flags[2], 1);
        check("status2", st2, 4'h2);
        use2 = 1'b1;
        step(2);
        check("code", code, 3'h2);
        check("code7", code7, 3'h2);
        use2 = 1'b0;
        check("irq", irq_n, 1);
        $display("test levels done");
        i_host.release_write();
        check("active", active, 1);
        check("soft", ss_run, 1);
        ssd = 1'b1;
        shrt = 1'b1;
        step(3 * MS);
        check("short", flags[5], 0);
        step(2 * MS);
        check("short", flags[5], 1);
        check("active", active, 0);
        shrt = 1'b0;
        ssd = 1'b0;
        i_host.release_write();
        check("soft", ss_run, 1);
        ssd = 1'b1;
        step(2);
        ovp = 1'b1;
        step(2);
        check("pump", pump, 0);
        check("active", active, 1);
        check("ovp", flags[3], 1);
        i_host.clear(6'h08);
        step(2);
        check("ovp", flags[3], 0);
        ovp = 1'b0;
        step(2);
        check("pump", pump, 1);
        ovp = 1'b1;
        step(2);
        check("ovp", flags[3], 1);
        ovp = 1'b0;
        hot = 1'b1;
        step(2);
        check("hot", flags[4], 1);
        check("active", active, 0);
        i_host.clear(6'h10);
        step(1);
        check("hot", flags[4], 1);
        hot = 1'b0;
        i_host.clear(6'h10);
        step(3);
        check("hot", flags[4], 0);
        fdone = 1'b1;
        step(1);
        fdone = 1'b0;
        check("fade", flags[0], 1);
        i_host.clear(6'h01);
        step(1);
        check("fade", flags[0], 0);
        // cooled: leave the hot state again so the sinks can run
        i_host.release_write();
        check("active", active, 1);
        check("release", rel, 1);
        $display("test faults done");
        sel = 7'h01;
        off_t = 14'h0001;
        sen = 7'h01;
        step(100 * MS);
        check("blink", isc_on, 7'h01);
        step(200 * MS);
        check("blink", isc_on, 7'h00);
        step(550 * MS);
        check("blink", isc_on, 7'h01);
        sen = 7'h00;
        step(2 * MS);
        check("stop", isc_on, 7'h00);
        off_t = 14'h0000;
        sen = 7'h01;
        step(300 * MS);
        check("steady", isc_on, 7'h01);
        $display("test blink done");
        summarize();
    end
endmodule : tb_backlight_level_blink_fault_ctrl
`default_nettype wire
